//--- rtl/pdc_defines.vh
// Constants for the PLL divider configuration block.
// Assumes an APB slave with 32-bit data, word-aligned registers.
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// Register indices; byte address is four times the index
`define PDC_IDX_REF_LOW      8'h54
`define PDC_IDX_OUT_REF_HIGH 8'h55
`define PDC_IDX_FB_LOW       8'h56
`define PDC_IDX_FB_HIGH      8'h57
`define PDC_IDX_ENABLE       8'h59
`define PDC_IDX_STATUS       8'h5b

// Reset values
`define PDC_RST_REF_LOW      8'h00
`define PDC_RST_OUT_REF_HIGH 8'h48
`define PDC_RST_FB_LOW       8'h78
`define PDC_RST_FB_HIGH      8'h40
`define PDC_RST_ENABLE       8'h41
`define PDC_ENABLE_MASK      8'h7f

// Field positions
`define PDC_OUT_DIV_MSB      7
`define PDC_OUT_DIV_LSB      4
`define PDC_REF_HIGH_MSB     1
`define PDC_REF_HIGH_LSB     0
`define PDC_FB_HIGH_MSB      3
`define PDC_FB_HIGH_LSB      0
`define PDC_REF_EN_BIT       4

// Status layout
`define PDC_STAT_REF_MSB     9
`define PDC_STAT_FB_LSB      16
`define PDC_STAT_OUT_LSB     28

// Unsupported reference code
`define PDC_REF_BAD_CODE     10'h002

`endif

//--- rtl/pdc_sync_word.v
// Two-flop synchroniser for single handshake toggles.
// Assumes each toggle stays put until the far side acknowledges it.
`timescale 1ns/1ps
`default_nettype none
module pdc_sync_word #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // Only sync_q is read outside; meta_q may go metastable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // pdc_sync_word
`default_nettype wire

//--- rtl/pdc_clk_div.v
// Integer clock divider running on the clock it divides.
// Assumes the ratio is already synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module pdc_clk_div #(
  parameter W = 10
) (
  input  wire         clk_in,
  input  wire         rst_n,
  input  wire [W-1:0] ratio,
  output wire         clk_out
);
  reg  [W-1:0] cnt_q;
  reg          div_q;
  wire [W-1:0] last = ratio - {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] half = ratio >> 1;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
      div_q <= 1'b0;
    end else begin
      if (cnt_q >= last) begin
        cnt_q <= {W{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
      div_q <= (cnt_q < half);
    end
  end

  // Ratio below two passes the clock straight through
  assign clk_out = (ratio < 2) ? clk_in : div_q;
endmodule // pdc_clk_div
`default_nettype wire

//--- rtl/pdc_pll_divider_config.v
// PLL divider configuration: APB registers and three dividers.
// Assumes APB master on pclk; PLL clocks come from outside.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.vh"
module pdc_pll_divider_config #(
  parameter REF_W = 10,
  parameter FB_W  = 12,
  parameter OUT_W = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        ref_clk,
  input  wire        vco_clk,
  input  wire        pll_out_clk,
  output wire        pfd_ref_clk,
  output wire        pfd_fb_clk,
  output wire        pll_div_clk
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00) begin
        reg_sel = 3'd7;
      end else if (addr[9:2] == `PDC_IDX_REF_LOW) begin
        reg_sel = 3'd0;
      end else if (addr[9:2] == `PDC_IDX_OUT_REF_HIGH) begin
        reg_sel = 3'd1;
      end else if (addr[9:2] == `PDC_IDX_FB_LOW) begin
        reg_sel = 3'd2;
      end else if (addr[9:2] == `PDC_IDX_FB_HIGH) begin
        reg_sel = 3'd3;
      end else if (addr[9:2] == `PDC_IDX_ENABLE) begin
        reg_sel = 3'd4;
      end else if (addr[9:2] == `PDC_IDX_STATUS) begin
        reg_sel = 3'd5;
      end else begin
        reg_sel = 3'd7;
      end
      if (addr[11:10] != 2'b00) begin
        reg_sel = 3'd7;
      end
    end
  endfunction

  wire [2:0] sel      = reg_sel(paddr);
  wire       setup    = psel & ~penable;
  wire       wr_acc   = psel & penable & pwrite;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel == 3'd7);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] ref_low_q;
  reg [7:0] out_ref_high_q;
  reg [7:0] fb_low_q;
  reg [7:0] fb_high_q;
  reg [7:0] enable_q;

  // Factory trim bits are stored as written; software keeps them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_low_q      <= `PDC_RST_REF_LOW;
      out_ref_high_q <= `PDC_RST_OUT_REF_HIGH;
      fb_low_q       <= `PDC_RST_FB_LOW;
      fb_high_q      <= `PDC_RST_FB_HIGH;
      enable_q       <= `PDC_RST_ENABLE;
    end else if (wr_acc) begin
      // Each byte lands directly in the live ratio
      if (sel == 3'd0) begin
        ref_low_q <= pwdata[7:0];
      end else if (sel == 3'd1) begin
        out_ref_high_q <= pwdata[7:0];
      end else if (sel == 3'd2) begin
        fb_low_q <= pwdata[7:0];
      end else if (sel == 3'd3) begin
        fb_high_q <= pwdata[7:0];
      end else if (sel == 3'd4) begin
        enable_q <= pwdata[7:0] & `PDC_ENABLE_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective ratios

  wire [REF_W-1:0] ref_code = {out_ref_high_q[`PDC_REF_HIGH_MSB:
                                              `PDC_REF_HIGH_LSB],
                               ref_low_q};
  wire [FB_W-1:0]  fb_code  = {fb_high_q[`PDC_FB_HIGH_MSB:`PDC_FB_HIGH_LSB],
                               fb_low_q};
  wire [OUT_W-1:0] out_code = out_ref_high_q[`PDC_OUT_DIV_MSB:
                                             `PDC_OUT_DIV_LSB];
  wire             ref_en   = enable_q[`PDC_REF_EN_BIT];

  // Disabled divider or code two forces pass-through
  wire [REF_W-1:0] ref_eff = (!ref_en || ref_code == `PDC_REF_BAD_CODE) ?
                             {{(REF_W-1){1'b0}}, 1'b1} : ref_code;

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered in the setup cycle

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (sel == 3'd0) begin
        prdata <= {24'h00_0000, ref_low_q};
      end else if (sel == 3'd1) begin
        prdata <= {24'h00_0000, out_ref_high_q};
      end else if (sel == 3'd2) begin
        prdata <= {24'h00_0000, fb_low_q};
      end else if (sel == 3'd3) begin
        prdata <= {24'h00_0000, fb_high_q};
      end else if (sel == 3'd4) begin
        prdata <= {24'h00_0000, enable_q};
      end else if (sel == 3'd5) begin
        prdata <= {out_code, fb_code, 6'h00, ref_eff};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dividers, each on its own PLL clock

  // Domain 0 reference, 1 feedback, 2 output; fields packed low to high
  localparam CFG_W = REF_W + FB_W + OUT_W;

  wire [2:0]       dom_clk  = {pll_out_clk, vco_clk, ref_clk};
  wire [CFG_W-1:0] cfg_word = {out_code, fb_code, ref_eff};
  wire [2:0]       div_clk;

  // Divided reference feeds the phase detector
  assign pfd_ref_clk = div_clk[0];
  // VCO divided inside the loop as feedback
  assign pfd_fb_clk  = div_clk[1];
  // Output codes 0 and 1 both leave the clock undivided
  assign pll_div_clk = div_clk[2];

  ////////////////////////////////////////////////////////////////////////
  // Ratio hand-over, one toggle handshake per PLL clock domain

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_dom
      localparam W   = (g == 0) ? REF_W : ((g == 1) ? FB_W : OUT_W);
      localparam LSB = (g == 0) ? 0 : ((g == 1) ? REF_W : REF_W + FB_W);

      wire [W-1:0] live = cfg_word[LSB+W-1:LSB];
      wire         dom_rst_n;
      wire         req_dst;
      wire         ack_src;
      reg  [1:0]   rst_q;
      reg  [W-1:0] hold_q;
      reg          req_q;
      reg          ack_q;
      reg  [W-1:0] ratio_q;

      // Reset asserts at once but releases in step with the PLL clock
      always @(posedge dom_clk[g] or negedge presetn) begin
        if (!presetn) begin
          rst_q <= 2'b00;
        end else begin
          rst_q <= {rst_q[0], 1'b1};
        end
      end

      assign dom_rst_n = rst_q[1];

      // A new word is offered only once the last one was taken, so the
      // held word never moves while the far side may sample it
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold_q <= {W{1'b0}};
          req_q  <= 1'b0;
        end else if ((req_q == ack_src) && (hold_q != live)) begin
          hold_q <= live;
          req_q  <= ~req_q;
        end
      end

      pdc_sync_word #(.W(1)) u_req_sync (
        .clk   (dom_clk[g]),
        .rst_n (dom_rst_n),
        .d     (req_q),
        .q     (req_dst)
      );

      // The whole word lands at once; ratio bits never straddle an edge
      always @(posedge dom_clk[g] or negedge dom_rst_n) begin
        if (!dom_rst_n) begin
          ack_q   <= 1'b0;
          ratio_q <= {W{1'b0}};
        end else if (req_dst != ack_q) begin
          ack_q   <= req_dst;
          ratio_q <= hold_q;
        end
      end

      pdc_sync_word #(.W(1)) u_ack_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (ack_q),
        .q     (ack_src)
      );

      // Byte writes reach the divider as soon as the hand-over ends
      pdc_clk_div #(.W(W)) u_div (
        .clk_in  (dom_clk[g]),
        .rst_n   (dom_rst_n),
        .ratio   (ratio_q),
        .clk_out (div_clk[g])
      );
    end
  endgenerate

endmodule // pdc_pll_divider_config
`default_nettype wire

//--- testbench/pdc_sva.sv
// Checker for the PLL divider configuration block.
// Sees only the top-level ports; bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module pdc_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ref_q;
  logic [7:0] fb_q;
  wire acc = psel && penable;
  wire rds = psel && !penable && !pwrite;
  wire map = paddr inside {12'h150, 12'h154, 12'h158, 12'h15c,
                           12'h164, 12'h16c};
  // Shadows of the two low bytes, so read data is checked end to end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 8'h00;
      fb_q  <= 8'h78;
    end else if (acc && pwrite && paddr == 12'h150) begin
      ref_q <= pwdata[7:0];
    end else if (acc && pwrite && paddr == 12'h158) begin
      fb_q <= pwdata[7:0];
    end
  end
  pready_high_a: assert property (pready) else $error("pready low");
  err_window_a: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  err_unmap_a: assert property (acc && !map |-> pslverr)
    else $error("unmapped access accepted");
  err_map_a: assert property (acc && map |-> !pslverr)
    else $error("mapped access refused");
  rd_hold_a: assert property (!rds |=> $stable(prdata))
    else $error("read data moved");
  rd_unmap_a: assert property (rds && !map |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  ref_rd_a: assert property (rds && paddr == 12'h150 |=>
    prdata == {24'h0, ref_q}) else $error("ref byte wrong");
  fb_rd_a: assert property (rds && paddr == 12'h158 |=>
    prdata == {24'h0, fb_q}) else $error("prescale byte wrong");
  cover property (acc && pwrite && paddr == 12'h164);
  cover property (acc && !map);
  cover property (rds && paddr == 12'h16c);
endmodule // pdc_sva
`default_nettype wire

//--- testbench/pdc_pll_divider_config_tb.sv
// Bench for the PLL divider configuration block.
// Drives APB and three PLL clocks; measures divided periods.
`timescale 1ns/1ps
`default_nettype none
module pdc_pll_divider_config_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ref_clk = 0, vco_clk = 0, pll_out_clk = 0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pfd_ref_clk, pfd_fb_clk, pll_div_clk;
  int miscompares, checked, cnt[3], last[3], per[3], edges[3];
  logic [11:0] ra[5] = '{12'h150, 12'h154, 12'h158, 12'h15c, 12'h164};
  logic [31:0] rv[5] = '{32'h0, 32'h48, 32'h78, 32'h40, 32'h41};
  wire [2:0] ic = {pll_out_clk, vco_clk, ref_clk};
  wire [2:0] dc = {pll_div_clk, pfd_fb_clk, pfd_ref_clk};
  pdc_pll_divider_config dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .ref_clk, .vco_clk,
    .pll_out_clk, .pfd_ref_clk, .pfd_fb_clk, .pll_div_clk);
  initial forever #5 pclk = ~pclk;
  initial forever #2 ref_clk = ~ref_clk;
  initial forever #1 vco_clk = ~vco_clk;
  initial forever #3 pll_out_clk = ~pll_out_clk;
  // Count on falling edges so a pass-through output still reads as one
  for (genvar i = 0; i < 3; i++) begin : g_m
    always @(negedge ic[i]) cnt[i]++;
    always @(posedge dc[i]) begin
      per[i] = cnt[i] - last[i];
      last[i] = cnt[i];
      edges[i]++;
    end
  end
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    er = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      stop_test();
    end else begin
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h0, d});
  endtask
  // Long fixed wait: the largest ratio needs a few output periods
  // A stuck output would leave an old period behind, so edges are counted
  task automatic ck(input int i, input int e);
    int n0;
    n0 = edges[i];
    repeat (2500) @(posedge pclk);
    chk(per[i], e);
    chk(edges[i] - n0 > 1, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk(rd, rv[i]);
    end
    apb(0, 12'h16c, 0);
    chk(rd, 32'h4078_0001);
    apb(0, 12'h160, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1, 12'h151, 32'hff);
    chk({31'h0, er}, 32'h1);
    apb(0, 12'h150, 0);
    chk(rd, 32'h0);
    $display("test registers done");
    ck(0, 1);
    wr(12'h150, 8'h05);
    ck(0, 1);
    wr(12'h164, 8'hd1);
    apb(0, 12'h164, 0);
    chk(rd, 32'h51);
    ck(0, 5);
    wr(12'h150, 8'h02);
    ck(0, 1);
    apb(0, 12'h16c, 0);
    chk(rd[9:0], 10'h001);
    wr(12'h150, 8'h01);
    ck(0, 1);
    wr(12'h150, 8'h00);
    ck(0, 1);
    wr(12'h150, 8'hff);
    wr(12'h154, 8'h4b);
    ck(0, 1023);
    apb(0, 12'h16c, 0);
    chk(rd[9:0], 10'h3ff);
    $display("test reference done");
    for (int k = 0; k < 5; k++) begin
      wr(12'h154, {k[3:0], 4'h8});
      ck(2, k < 2 ? 1 : k);
    end
    $display("test output done");
    ck(1, 120);
    wr(12'h15c, 8'h4f);
    wr(12'h158, 8'hff);
    ck(1, 4095);
    wr(12'h15c, 8'h40);
    wr(12'h158, 8'h02);
    ck(1, 2);
    wr(12'h158, 8'h01);
    ck(1, 1);
    $display("test prescale done");
    stop_test();
  end
endmodule // pdc_pll_divider_config_tb
bind pdc_pll_divider_config pdc_sva u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
`default_nettype wire
